// [logic/mdctl_pkg.sv]
// Purpose: shared constants for the multidrop control and reset block
// Assumes: AXI4-Lite register bus, 32-bit data, 100 MHz clock
// Notes:   register offsets are byte addresses, one word per register
package mdctl_pkg;
  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [7:0] OFS_IER    = 8'h00;
  localparam logic [7:0] OFS_FCR    = 8'h04;
  localparam logic [7:0] OFS_ISR    = 8'h08;
  localparam logic [7:0] OFS_LCR    = 8'h0c;
  localparam logic [7:0] OFS_MCR    = 8'h10;
  localparam logic [7:0] OFS_LSR    = 8'h14;
  localparam logic [7:0] OFS_MSR    = 8'h18;
  localparam logic [7:0] OFS_EXTRA_FEATURE_CTRL_REG   = 8'h1c;
  localparam logic [7:0] OFS_SPR    = 8'h20;
  localparam logic [7:0] OFS_DIVL   = 8'h24;
  localparam logic [7:0] OFS_DIVH   = 8'h28;
  localparam logic [7:0] OFS_TXCNT  = 8'h2c;
  localparam logic [7:0] OFS_RXCNT  = 8'h30;
  localparam logic [7:0] OFS_EFR    = 8'h34;
  localparam logic [7:0] OFS_TXTHR  = 8'h38;
  localparam logic [7:0] OFS_RXTHR  = 8'h3c;
  localparam logic [7:0] OFS_FLWH   = 8'h40;
  localparam logic [7:0] OFS_FLWL   = 8'h44;
  localparam logic [7:0] OFS_PRES   = 8'h48;
  localparam logic [7:0] OFS_TURN   = 8'h4c;
  localparam logic [7:0] OFS_FC2    = 8'h50;
  localparam logic [7:0] OFS_FC1    = 8'h54;
  localparam logic [7:0] OFS_XCH0   = 8'h58;
  localparam int         NUM_REGS   = 26;
  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int FC2_POL  = 5;
  localparam int FC2_CON  = 4;
  localparam int FC2_SEL  = 3;
  localparam int FC2_TXO  = 2;
  localparam int FC2_RXO  = 1;
  localparam int FC2_MD   = 0;
  localparam int FC1_SRST = 1;
  localparam logic [7:0] FC2_MASK = 8'h3f;
  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ISR  = 8'h01;
  localparam logic [7:0] RST_LSR  = 8'h60;
  localparam logic [7:0] RST_SPR  = 8'h01;
  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int         CLK_MHZ      = 100;
  localparam int         SRST_CLOCKS  = 4;   // osc clocks to finish reset
  localparam logic [2:0] SRST_CYC     = 3'(SRST_CLOCKS - 1);
  localparam int         BAUD_DIV_DEF = 868; // cycles per bit time
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : mdctl_pkg

// [logic/pin_sync.sv]
// Purpose: three-stage synchroniser for a group of pin inputs
// Assumes: pins are asynchronous to aclk
// Notes:   out of reset, output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] pin_in,
  output var  logic [W-1:0] level_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // ********************************************************************
  // stages
  // ********************************************************************
  // stage one feeds only stage two, avoiding metastable fan-out
  always_ff @(posedge aclk) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end
  // accept a change once two settled stages agree
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          level_r[i] <= s3_r[i]; // take the pin level, no false change
        end else if (s2_r[i] == s3_r[i]) begin
          level_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// [logic/turn_timer.sv]
// Purpose: bit-time tick and turn-around countdown
// Assumes: load pulses when the last bit leaves the shifter
// Notes:   done pulses when the count reaches zero
`timescale 1ns/1ps
`default_nettype none
module turn_timer (
  input  wire logic        aclk,
  input  wire logic        clr,
  input  wire logic [15:0] bit_div,
  input  wire logic        load,
  input  wire logic [7:0]  delay,
  output var  logic        busy_r,
  output var  logic        done_r
);
  logic [15:0] div_r;
  logic [7:0]  cnt_r;
  wire         tick = (div_r == 16'h0000);
  // ********************************************************************
  // divider and countdown
  // ********************************************************************
  // bit-time enable; restarts on load so the first bit is whole
  always_ff @(posedge aclk) begin
    if (clr || load || tick) begin
      div_r <= bit_div - 16'h0001; // tick every bit_div cycles
    end else begin
      div_r <= div_r - 16'h0001;
    end
  end
  // zero delay finishes on the next cycle
  always_ff @(posedge aclk) begin
    done_r <= 1'b0;
    if (clr) begin
      busy_r <= 1'b0;
      cnt_r  <= 8'h00;
    end else if (load) begin
      busy_r <= 1'b1;
      cnt_r  <= delay;
    end else if (busy_r && (cnt_r == 8'h00)) begin
      busy_r <= 1'b0;
      done_r <= 1'b1;
    end else if (busy_r && tick) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule : turn_timer
`default_nettype wire

// [logic/mdctl_top.sv]
// Purpose: multidrop control register, direction pin and reset state
// Assumes: AXI4-Lite slave; UART core attaches through status ports
// Notes:   registers answer one cycle after both write halves arrive
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module mdctl_top #(
  parameter logic [15:0] BIT_DIV = 16'(mdctl_pkg::BAUD_DIV_DEF)
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [3:0]  modem_pins,
  input  wire logic        tx_active,
  input  wire logic        tx_last_bit_out,
  input  wire logic        tx_serial,
  output var  logic        txd_r,
  output var  logic        rts_n_r,
  output var  logic        dtr_n_r,
  output var  logic        irq_out_r,
  output var  logic        irq_oe_r,
  output var  logic        tx_en_r,
  output var  logic        rx_en_r,
  output var  logic        multidrop_r,
  output var  logic        uart_rst_r
);
  // ********************************************************************
  // reset sequencing
  // ********************************************************************
  logic       srst_busy_r;
  logic [2:0] srst_cnt_r;
  logic       soft_req;
  // held high by external or software reset; only external reset also clears the bus port
  wire        rst_all = !aresetn || srst_busy_r;

  // software reset runs four clocks, then the trigger bit reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      srst_busy_r <= 1'b0;
      srst_cnt_r  <= 3'h0;
    end else if (soft_req && !srst_busy_r) begin
      srst_busy_r <= 1'b1;
      srst_cnt_r  <= mdctl_pkg::SRST_CYC;
    end else if (srst_busy_r && srst_cnt_r == 3'h0) begin
      srst_busy_r <= 1'b0;
    end else if (srst_busy_r) begin
      srst_cnt_r <= srst_cnt_r - 3'h1;
    end
  end

  // ********************************************************************
  // bus handshake
  // ********************************************************************
  logic       aw_hold_r;
  logic       w_hold_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        do_wr   = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire        ar_fire = s_axi_arvalid && s_axi_arready;
  logic       wr_hit;

  // address and data accepted in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= mdctl_pkg::RESP_OKAY;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_r && !aw_fire && !s_axi_bvalid;
      s_axi_wready  <= !w_hold_r && !w_fire && !s_axi_bvalid;
      if (aw_fire) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? mdctl_pkg::RESP_OKAY
                               : mdctl_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // register file
  // ********************************************************************
  logic [7:0] regs_r [mdctl_pkg::NUM_REGS];

  // word index of a byte address; bit 7 is dropped, so above 0x7f the index wraps and mapped checks it
  function automatic logic [4:0] reg_index(input logic [7:0] addr);
    reg_index = addr[6:2];
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr[1:0] == 2'b00) && (addr[7] == 1'b0) &&
             (reg_index(addr) < 5'(mdctl_pkg::NUM_REGS));
  endfunction

  assign wr_hit = mapped(aw_addr_r);
  wire [4:0]  wr_idx  = reg_index(aw_addr_r);
  wire        wr_en   = do_wr && wr_hit && w_strb_r[0];
  wire [7:0]  wr_byte = w_data_r[7:0];
  wire        wr_fc1  = wr_en && aw_addr_r == mdctl_pkg::OFS_FC1;
  assign soft_req = wr_fc1 && wr_byte[mdctl_pkg::FC1_SRST];

  // the modem status register lives outside the writable array
  logic [7:0] msr_r;
  wire  [3:0] pins_sync;

  pin_sync #(.W(4)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_in  (modem_pins),
    .level_r (pins_sync)
  );

  // reset values per register; divisor and flow characters keep value
  function automatic logic [7:0] reset_val(input int idx);
    case (8'(idx * 4))
      mdctl_pkg::OFS_ISR: reset_val = mdctl_pkg::RST_ISR;
      mdctl_pkg::OFS_LSR: reset_val = mdctl_pkg::RST_LSR;
      mdctl_pkg::OFS_SPR: reset_val = mdctl_pkg::RST_SPR;
      default:            reset_val = mdctl_pkg::RST_ZERO;
    endcase
  endfunction

  function automatic logic no_reset(input int idx);
    no_reset = (8'(idx * 4) == mdctl_pkg::OFS_DIVL) ||
               (8'(idx * 4) == mdctl_pkg::OFS_DIVH) ||
               (8'(idx * 4) >= mdctl_pkg::OFS_XCH0);
  endfunction

  function automatic logic read_only(input int idx);
    read_only = (8'(idx * 4) == mdctl_pkg::OFS_ISR) ||
                (8'(idx * 4) == mdctl_pkg::OFS_LSR) ||
                (8'(idx * 4) == mdctl_pkg::OFS_MSR);
  endfunction

  genvar g;
  generate
    for (g = 0; g < mdctl_pkg::NUM_REGS; g++) begin : g_reg
      always_ff @(posedge aclk) begin
        if (rst_all && !no_reset(g)) begin
          regs_r[g] <= reset_val(g);
        end else if (wr_en && wr_idx == 5'(g) && !read_only(g)) begin
          if (8'(g * 4) == mdctl_pkg::OFS_FC2) begin
            regs_r[g] <= wr_byte & mdctl_pkg::FC2_MASK;
          end else if (8'(g * 4) == mdctl_pkg::OFS_FC1) begin
            regs_r[g] <= wr_byte & ~8'h02;
          end else begin
            regs_r[g] <= wr_byte;
          end
        end
      end
    end
  endgenerate

  // upper nibble tracks pins, change flags cleared at reset
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      msr_r <= {pins_sync, 4'h0};
    end else begin
      msr_r <= {pins_sync, msr_r[3:0] | (pins_sync ^ msr_r[7:4])};
    end
  end

  // ********************************************************************
  // read channel
  // ********************************************************************
  wire [4:0]  rd_idx  = reg_index(s_axi_araddr);
  wire        rd_hit  = mapped(s_axi_araddr);
  wire        rd_fc1  = s_axi_araddr == mdctl_pkg::OFS_FC1;
  wire        rd_msr  = s_axi_araddr == mdctl_pkg::OFS_MSR;
  wire [7:0]  rd_reg  = rd_hit ? regs_r[rd_idx] : 8'h00;
  wire [7:0]  rd_byte = rd_msr ? msr_r
                      : rd_fc1 ? {rd_reg[7:2], srst_busy_r, rd_reg[0]}
                      : rd_reg;

  // one read at a time; answer the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= mdctl_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? mdctl_pkg::RESP_OKAY
                               : mdctl_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // mode decode
  // ********************************************************************
  localparam int FC2_IDX = int'(mdctl_pkg::OFS_FC2) / 4;
  localparam int MCR_IDX = int'(mdctl_pkg::OFS_MCR) / 4;
  localparam int TRN_IDX = int'(mdctl_pkg::OFS_TURN) / 4;
  localparam int ISR_IDX = int'(mdctl_pkg::OFS_ISR) / 4;
  wire [7:0] fc2      = regs_r[FC2_IDX];
  wire [7:0] modem_control_reg      = regs_r[MCR_IDX];
  wire       md_on    = fc2[mdctl_pkg::FC2_MD];
  wire       dir_ctl  = md_on && fc2[mdctl_pkg::FC2_CON];
  wire       dir_dtr  = fc2[mdctl_pkg::FC2_SEL];
  wire       dir_inv  = fc2[mdctl_pkg::FC2_POL];

  // ********************************************************************
  // turn-around
  // ********************************************************************
  logic turn_busy;
  logic turn_done;
  logic sending_r;

  turn_timer u_turn (
    .aclk    (aclk),
    .clr     (rst_all || !dir_ctl),
    .bit_div (BIT_DIV),
    .load    (tx_last_bit_out && dir_ctl),
    .delay   (regs_r[TRN_IDX]),
    .busy_r  (turn_busy),
    .done_r  (turn_done)
  );

  // transmit direction held from first bit until delay expires
  always_ff @(posedge aclk) begin
    if (rst_all || !dir_ctl) begin
      sending_r <= 1'b0;
    end else if (tx_active && tx_en_r) begin
      sending_r <= 1'b1;
    end else if (turn_done) begin
      sending_r <= 1'b0;
    end
  end

  // low while sending, high while receiving, flipped by polarity bit
  wire dir_level = (~sending_r) ^ dir_inv;
  wire rts_nxt   = (dir_ctl && !dir_dtr) ? dir_level : ~modem_control_reg[1];
  wire dtr_nxt   = (dir_ctl &&  dir_dtr) ? dir_level : ~modem_control_reg[0];

  // ********************************************************************
  // output pins
  // ********************************************************************
  // all pins registered; reset drives txd, rts, dtr and the enables high, multidrop low, and floats interrupt
  always_ff @(posedge aclk) begin
    if (rst_all) begin
      txd_r       <= 1'b1;
      rts_n_r     <= 1'b1;
      dtr_n_r     <= 1'b1;
      irq_out_r   <= 1'b0;
      irq_oe_r    <= 1'b0;
      tx_en_r     <= 1'b1;
      rx_en_r     <= 1'b1;
      multidrop_r <= 1'b0;
      uart_rst_r  <= 1'b1;
    end else begin
      txd_r       <= tx_en_r ? tx_serial : 1'b1;
      rts_n_r     <= rts_nxt;
      dtr_n_r     <= dtr_nxt;
      irq_out_r   <= 1'b0;
      irq_oe_r    <= 1'b0;
      tx_en_r     <= !fc2[mdctl_pkg::FC2_TXO];
      rx_en_r     <= !fc2[mdctl_pkg::FC2_RXO];
      multidrop_r <= md_on;
      uart_rst_r  <= 1'b0;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  pin_reset_a: assert property (@(posedge aclk)
    rst_all |=> txd_r && rts_n_r && dtr_n_r && !irq_oe_r)
    else $error("pins not at reset level");
  tx_disable_a: assert property (@(posedge aclk) disable iff (rst_all)
    fc2[mdctl_pkg::FC2_TXO] |=> !tx_en_r)
    else $error("transmitter not disabled");
  rx_disable_a: assert property (@(posedge aclk) disable iff (rst_all)
    fc2[mdctl_pkg::FC2_RXO] |=> !rx_en_r)
    else $error("receiver not disabled");
  mode_follow_a: assert property (@(posedge aclk) disable iff (rst_all)
    1'b1 |=> multidrop_r == $past(md_on))
    else $error("mode output stale");
  dir_rts_a: assert property (@(posedge aclk) disable iff (rst_all)
    dir_ctl && !dir_dtr |=> rts_n_r == $past(dir_level))
    else $error("direction level wrong");
  dir_dtr_a: assert property (@(posedge aclk) disable iff (rst_all)
    dir_ctl && dir_dtr |=> dtr_n_r == $past(dir_level))
    else $error("ready pin not selected");
  dir_free_a: assert property (@(posedge aclk) disable iff (rst_all)
    !dir_ctl |=> rts_n_r == !$past(modem_control_reg[1]))
    else $error("pin driven without enable");
  srst_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(srst_busy_r) |-> srst_busy_r [*4] ##1 !srst_busy_r)
    else $error("software reset length wrong");
  reset_vals_a: assert property (@(posedge aclk)
    rst_all |=> regs_r[ISR_IDX] == mdctl_pkg::RST_ISR &&
                regs_r[FC2_IDX] == 8'h00)
    else $error("register not cleared");
  msr_clear_a: assert property (@(posedge aclk)
    rst_all |=> msr_r[3:0] == 4'h0)
    else $error("modem change flags not cleared");
  fc2_res_a: assert property (@(posedge aclk) disable iff (rst_all)
    fc2[7:6] == 2'b00)
    else $error("reserved bits set");
  dir_hold_a: assert property (@(posedge aclk)
    disable iff (rst_all) turn_busy && tx_en_r |-> sending_r)
    else $error("direction released during delay");
endmodule : mdctl_top
`default_nettype wire

// [bench/core_stub.sv]
// Purpose: stand-in for the uart core transmit side
// Assumes: go is a one-cycle pulse from the bench
// Notes:   a frame is FRAME cycles of low data, then a last-bit pulse
`timescale 1ns/1ps
`default_nettype none
module core_stub #(
  parameter int FRAME = 10
) (
  input  wire logic aclk,
  input  wire logic go,
  output var  logic tx_active,
  output var  logic tx_last_bit_out,
  output var  logic tx_serial
);
  int cnt = 0;
  // frame countdown; the line idles high between frames
  always_ff @(posedge aclk) begin
    tx_last_bit_out <= (cnt == 1);
    if (go) cnt <= FRAME;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  assign tx_active = (cnt != 0);
  assign tx_serial = (cnt == 0);  // data held low keeps txd easy to judge
endmodule : core_stub
`default_nettype wire

// [bench/mdctl_top_test.sv]
// Purpose: register, reset and direction pin checks for mdctl_top
// Assumes: bench is the AXI4-Lite master, core_stub plays the core
// Notes:   BIT_DIV of 4 keeps turn-around waits short
`timescale 1ns/1ps
`default_nettype none
module mdctl_top_test;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, go = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
  logic [31:0] wdata   = 32'h0, rd, rdata;
  logic [3:0]  pins    = 4'ha;
  logic [1:0]  bresp, rresp, rs, bs;
  logic        awready, wready, bvalid, arready, rvalid, act, last, ser;
  logic        txd, rts_n, dtr_n, irq_o, irq_oe, tx_en, rx_en, md, urst;
  int          n_fail = 0;
  int          comparisons = 0;
  // registers that clear to zero; feature_control_one last on purpose
  logic [7:0]  zl [16] = '{mdctl_pkg::OFS_IER, mdctl_pkg::OFS_FCR,
    mdctl_pkg::OFS_LCR, mdctl_pkg::OFS_MCR, mdctl_pkg::OFS_EXTRA_FEATURE_CTRL_REG,
    mdctl_pkg::OFS_TXCNT, mdctl_pkg::OFS_RXCNT, mdctl_pkg::OFS_EFR,
    mdctl_pkg::OFS_TXTHR, mdctl_pkg::OFS_RXTHR, mdctl_pkg::OFS_FLWH,
    mdctl_pkg::OFS_FLWL, mdctl_pkg::OFS_PRES, mdctl_pkg::OFS_TURN,
    mdctl_pkg::OFS_FC2, mdctl_pkg::OFS_FC1};

  always #5 aclk = ~aclk;

  mdctl_top #(.BIT_DIV(16'h0004)) mdctl_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modem_pins(pins),
    .tx_active(act), .tx_last_bit_out(last), .tx_serial(ser),
    .txd_r(txd), .rts_n_r(rts_n), .dtr_n_r(dtr_n), .irq_out_r(irq_o),
    .irq_oe_r(irq_oe), .tx_en_r(tx_en), .rx_en_r(rx_en),
    .multidrop_r(md), .uart_rst_r(urst));

  core_stub #(.FRAME(10)) core_stub_inst (.aclk(aclk), .go(go),
    .tx_active(act), .tx_last_bit_out(last), .tx_serial(ser));

  // ********
  // tasks
  // ********
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic hang;
    n_fail++;
    $display("[ERR] t=%0t wait limit reached", $time);
    results();
  endtask : hang

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // bus writes hold each channel until its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k <= 64; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bs = bresp;
    bready <= 1'b0;
    if (k > 64) hang();
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k <= 64; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (k > 64) hang();
  endtask : rdr

  task automatic reset_state;
    foreach (zl[i]) begin
      rdr(zl[i]);
      chk(rd, 32'h0);
    end
    chk({30'h0, rs}, {30'h0, mdctl_pkg::RESP_OKAY});
    rdr(mdctl_pkg::OFS_ISR);
    chk(rd, 32'h01);
    rdr(mdctl_pkg::OFS_LSR);
    chk(rd, 32'h60);
    rdr(mdctl_pkg::OFS_MSR);
    chk(rd, {24'h0, pins, 4'h0});
    rdr(mdctl_pkg::OFS_SPR);
    chk(rd, 32'h01);
    chk({27'h0, irq_o, txd, rts_n, dtr_n, irq_oe}, 32'h0e);
  endtask : reset_state

  // one core frame under feature_control_two value f
  task automatic frame(input logic [7:0] f);
    logic drv, txl, rxl;
    int   k;
    drv = f[0] & f[4];
    txl = drv ? f[5] : 1'b1;
    rxl = drv ? ~f[5] : 1'b1;
    wr(mdctl_pkg::OFS_FC2, f);
    @(negedge aclk);
    chk({29'h0, tx_en, rx_en, md}, {29'h0, ~f[2], ~f[1], f[0]});
    @(posedge aclk);
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (5) @(negedge aclk);
    chk({30'h0, txd, f[3] ? dtr_n : rts_n}, {30'h0, f[2], txl});
    chk({31'h0, f[3] ? rts_n : dtr_n}, 32'h1);
    for (k = 0; k <= 64; k++) begin
      @(posedge aclk);
      if (last) break;
    end
    if (k > 64) hang();
    repeat (7) @(negedge aclk);
    chk({31'h0, f[3] ? dtr_n : rts_n}, {31'h0, txl});
    repeat (9) @(negedge aclk);
    chk({31'h0, f[3] ? dtr_n : rts_n}, {31'h0, rxl});
  endtask : frame

  // ********
  // tests
  // ********
  initial begin
    int i;
    repeat (4) @(posedge aclk);
    #1;
    chk({28'h0, txd, rts_n, dtr_n, irq_oe}, 32'he);
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    reset_state();
    $display("test reset_values done");
    wr(mdctl_pkg::OFS_TURN, 8'h02);
    chk({30'h0, bs}, {30'h0, mdctl_pkg::RESP_OKAY});
    frame(8'hc7);
    rdr(mdctl_pkg::OFS_FC2);
    chk(rd, 32'h07);
    frame(8'h00);
    for (i = 0; i < 8; i++) frame({2'b00, i[2:0], 3'b001});
    $display("test direction_pin done");
    rdr(8'hfc);
    chk({30'h0, rs}, {30'h0, mdctl_pkg::RESP_SLVERR});
    chk(rd, 32'h0);
    wr(8'hfc, 8'h00);
    chk({30'h0, bs}, {30'h0, mdctl_pkg::RESP_SLVERR});
    $display("test unmapped done");
    for (i = 0; i < 15; i++) wr(zl[i], 8'h5a);
    wr(mdctl_pkg::OFS_SPR, 8'h5a);
    wr(mdctl_pkg::OFS_FC1, 8'h02);
    @(negedge aclk);
    chk({31'h0, urst}, 32'h1);
    repeat (6) @(posedge aclk);
    reset_state();
    $display("test soft_reset done");
    results();
  end
endmodule : mdctl_top_test
`default_nettype wire
